// [hw/cbv_pkg.sv]
package cbv_pkg;
    // widths of the configuration fields, then the pattern, region and vertical-output counts
    localparam int ADDR_W = 8;
    localparam int DATA_W = 12;
    localparam int POS_W = 10;
    localparam int EXT_W = 9;
    localparam int VPOS_W = 9;
    localparam int REP_W = 4;
    localparam int NPAT = 4;
    localparam int NREG = 5;
    localparam int NV = 4;

    typedef logic [POS_W-1:0] cbv_hpos_t;
    typedef logic [EXT_W-1:0] cbv_ext_t;
    typedef logic [VPOS_W-1:0] cbv_vpos_t;
    typedef logic [REP_W-1:0] cbv_rep_t;
    typedef logic [2:0] cbv_ptr_t;
    typedef logic [1:0] cbv_psel_t;
    typedef logic [NV-1:0] cbv_vlev_t;

    // register addresses
    localparam logic [ADDR_W-1:0] ADR_CTL_MASK = 8'h01;
    localparam logic [ADDR_W-1:0] ADR_CTL_RETIME = 8'h03;
    localparam logic [ADDR_W-1:0] ADR_CTL_HPULSE = 8'h0A;
    localparam logic [ADDR_W-1:0] ADR_HPOS = 8'h10;
    localparam logic [ADDR_W-1:0] ADR_EXTLEN = 8'h11;
    localparam logic [ADDR_W-1:0] ADR_PTR_BASE = 8'h18;
    localparam logic [ADDR_W-1:0] ADR_SEL_BASE = 8'h20;
    // pattern block: addr[7:6] = tag, [5:4] = pattern, [3:0] = field
    localparam logic [1:0] PAT_TAG = 2'h1;
    localparam logic [3:0] F_LEN = 4'h0;
    localparam logic [3:0] F_REP = 4'h1;
    localparam logic [3:0] F_START = 4'h2;
    localparam logic [3:0] F_TOG1 = 4'h4;
    localparam logic [3:0] F_TOG2 = 4'h8;

    // bit positions inside control words
    localparam int BIT_LEVEL = 0;
    localparam int BIT_SHUT = 1;
    localparam int BIT_RETIME = 0;
    localparam int BIT_PULSE = 0;
    localparam int BIT_EXTEND = 1;

    // spacing in pixels between the two blanking pulses
    localparam cbv_hpos_t PULSE_GAP = 10'h002;

    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b001,
        ST_EXTEND = 3'b010,
        ST_BLANK = 3'b100
    } cbv_hstate_t;
endpackage

// [hw/cbv_vpat_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface cbv_vpat_if;
    cbv_pkg::cbv_vpos_t len;
    cbv_pkg::cbv_rep_t rep;
    cbv_pkg::cbv_vlev_t start;
    cbv_pkg::cbv_vpos_t [cbv_pkg::NV-1:0] tog1;
    cbv_pkg::cbv_vpos_t [cbv_pkg::NV-1:0] tog2;
    logic line_start;
    cbv_pkg::cbv_vlev_t vout;
    modport ctrl (output len, rep, start, tog1, tog2, line_start, input vout);
    modport gen (input len, rep, start, tog1, tog2, line_start, output vout);
endinterface
`default_nettype wire

// [hw/cbv_vpat_gen.sv]
`timescale 1ns/100ps
`default_nettype none
module cbv_vpat_gen (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    cbv_vpat_if.gen vp
);
    typedef struct packed {
        cbv_pkg::cbv_vpos_t ppos;
        cbv_pkg::cbv_rep_t rnum;
        cbv_pkg::cbv_vlev_t lv;
    } cbv_gen_state_t;

    cbv_gen_state_t q;
    cbv_gen_state_t n;

    // one pass per repetition; each repetition restarts from the start level
    always_comb begin
        n = q;
        if (vp.line_start) begin
            n.ppos = '0;
            n.rnum = '0;
            n.lv = vp.start;
        end else if (vp.rep == '0) begin
            n.lv = vp.start;
        end else if (q.rnum < vp.rep) begin
            for (int v = 0; v < cbv_pkg::NV; v++) begin
                if (q.ppos == vp.tog1[v] || q.ppos == vp.tog2[v]) begin
                    n.lv[v] = ~q.lv[v];
                end
            end
            if (cbv_pkg::cbv_vpos_t'(q.ppos + 1'b1) >= vp.len) begin
                n.ppos = '0;
                n.rnum = cbv_pkg::cbv_rep_t'(q.rnum + 1'b1);
                // reload at the wrap: a toggle on the last pixel of a pass is lost
                n.lv = vp.start;
            end else begin
                n.ppos = cbv_pkg::cbv_vpos_t'(q.ppos + 1'b1);
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign vp.vout = q.lv;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    start_level_a: assert property (vp.line_start |=> vp.vout == $past(vp.start))
        else $error("line start did not load start level");
    zero_rep_a: assert property (!vp.line_start && vp.rep == '0 |=> vp.vout == $past(vp.start))
        else $error("zero repeat count did not hold start level");
    toggle_a: assert property (!vp.line_start && vp.rep != '0 && q.rnum < vp.rep
            && q.ppos == vp.tog1[0] && q.ppos != vp.tog2[0]
            && cbv_pkg::cbv_vpos_t'(q.ppos + 1'b1) < vp.len
            |=> vp.vout[0] != $past(vp.vout[0]))
        else $error("first vertical output missed its toggle");
endmodule // cbv_vpat_gen
`default_nettype wire

// [hw/cbv_timing_top.sv]
`timescale 1ns/100ps
`default_nettype none

module cbv_timing_top #(
    parameter int NREG = cbv_pkg::NREG,
    parameter int NPAT = cbv_pkg::NPAT
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic cfg_wr_in,
    input wire logic [cbv_pkg::ADDR_W-1:0] cfg_addr_in,
    input wire logic [cbv_pkg::DATA_W-1:0] cfg_data_in,
    input wire logic slave_mode_in,
    input wire logic line_sync_in,
    input wire logic mech_shutter_signal_in,
    input wire logic black_clamp_pulse_in,
    input wire logic [2:0] region_in,
    input wire logic shared_sync_gate_pin_in,
    output logic shared_sync_gate_pin_out,
    output logic shared_sync_gate_pin_oe_out,
    output logic horiz_clock_phase_a_out,
    output logic horiz_clock_phase_b_out,
    output logic [cbv_pkg::NV-1:0] vertical_clock_outputs_out,
    output logic black_clamp_pulse_out,
    output logic line_count_hold_out,
    output logic [cbv_pkg::POS_W-1:0] line_sub_counter_out,
    output logic blank_active_out
);
    // one bit wider than the position field, so pos plus gap never lands on an early pixel
    typedef logic [cbv_pkg::POS_W:0] cbv_blk_t;

    typedef struct packed {
        logic level;
        logic shut_sel;
        logic retime;
        logic pulse_en;
        logic ext_en;
        cbv_pkg::cbv_hpos_t hpos;
        cbv_pkg::cbv_ext_t ext_len;
        cbv_pkg::cbv_ptr_t [NREG-1:0] ptr;
        cbv_pkg::cbv_psel_t [NREG-1:0] sel;
        cbv_pkg::cbv_vpos_t [NPAT-1:0] len;
        cbv_pkg::cbv_rep_t [NPAT-1:0] rep;
        cbv_pkg::cbv_vlev_t [NPAT-1:0] start;
        cbv_pkg::cbv_vpos_t [NPAT-1:0][cbv_pkg::NV-1:0] tog1;
        cbv_pkg::cbv_vpos_t [NPAT-1:0][cbv_pkg::NV-1:0] tog2;
        cbv_pkg::cbv_hstate_t hst;
        cbv_pkg::cbv_ext_t ext_cnt;
        cbv_blk_t blk_cnt;
        cbv_pkg::cbv_hpos_t hsub;
        logic sync_d;
        logic gate_lat;
        logic blank_rt;
        logic hit_rt;
        logic h1;
        logic h2;
        logic sync_o;
        cbv_pkg::cbv_vlev_t vclk;
        logic clamp;
    } cbv_top_state_t;

    localparam cbv_top_state_t RST = '{hst: cbv_pkg::ST_ACTIVE, default: '0};

    cbv_top_state_t q;
    cbv_top_state_t n;

    logic sync_fall;
    logic blank_raw;
    logic blank_used;
    logic hit;
    logic hit_used;
    logic mask;
    cbv_pkg::cbv_psel_t pat;

    cbv_vpat_if vp();

    // region -> pointer -> select entry -> pattern; out-of-range gives 0
    function automatic cbv_pkg::cbv_psel_t pick_pattern(
        input cbv_top_state_t s,
        input logic [2:0] r
    );
        cbv_pkg::cbv_ptr_t e;
        e = (int'(r) < NREG) ? s.ptr[r] : '0;
        pick_pattern = (int'(e) < NREG) ? s.sel[e] : '0;
    endfunction

    // edge and mode decode, from registered state plus the live sync, mode, shutter and region inputs
    assign sync_fall = q.sync_d & ~line_sync_in;
    assign blank_raw = (q.hst != cbv_pkg::ST_ACTIVE);
    assign blank_used = q.retime ? q.blank_rt : blank_raw;
    assign hit = q.pulse_en
        && (q.blk_cnt == cbv_blk_t'(q.hpos)
        || q.blk_cnt == cbv_blk_t'(q.hpos) + cbv_blk_t'(cbv_pkg::PULSE_GAP));
    // retiming delays the pulses together with the level, so the pattern keeps its shape
    assign hit_used = q.retime ? q.hit_rt : hit;
    // shutter low vetoes the gate only when the select bit is set
    assign mask = slave_mode_in & q.gate_lat
        & (~q.shut_sel | mech_shutter_signal_in);
    assign pat = pick_pattern(q, region_in);

    // selected pattern feeds the shared sequencer
    assign vp.len = q.len[pat];
    assign vp.rep = q.rep[pat];
    assign vp.start = q.start[pat];
    assign vp.tog1 = q.tog1[pat];
    assign vp.tog2 = q.tog2[pat];
    // sequencer restarts on the raw sync edge, so extension never delays it
    assign vp.line_start = sync_fall;

    cbv_vpat_gen u_gen (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .vp(vp.gen)
    );

    // next-state logic: register writes, blanking, masking
    always_comb begin
        logic [1:0] p;
        logic [3:0] f;
        p = cfg_addr_in[5:4];
        f = cfg_addr_in[3:0];
        n = q;

        // control and configuration writes
        if (cfg_wr_in) begin
            case (cfg_addr_in)
                cbv_pkg::ADR_CTL_MASK: begin
                    n.level = cfg_data_in[cbv_pkg::BIT_LEVEL];
                    n.shut_sel = cfg_data_in[cbv_pkg::BIT_SHUT];
                end
                cbv_pkg::ADR_CTL_RETIME: begin
                    n.retime = cfg_data_in[cbv_pkg::BIT_RETIME];
                end
                cbv_pkg::ADR_CTL_HPULSE: begin
                    n.pulse_en = cfg_data_in[cbv_pkg::BIT_PULSE];
                    n.ext_en = cfg_data_in[cbv_pkg::BIT_EXTEND];
                end
                cbv_pkg::ADR_HPOS: begin
                    n.hpos = cfg_data_in[cbv_pkg::POS_W-1:0];
                end
                cbv_pkg::ADR_EXTLEN: begin
                    n.ext_len = cfg_data_in[cbv_pkg::EXT_W-1:0];
                end
                default: begin
                end
            endcase
            // region pointers and select entries
            for (int i = 0; i < NREG; i++) begin
                if (cfg_addr_in == cbv_pkg::ADDR_W'(cbv_pkg::ADR_PTR_BASE + i)) begin
                    n.ptr[i] = cfg_data_in[2:0];
                end
                if (cfg_addr_in == cbv_pkg::ADDR_W'(cbv_pkg::ADR_SEL_BASE + i)) begin
                    n.sel[i] = cfg_data_in[1:0];
                end
            end
            // per-pattern fields
            if (cfg_addr_in[7:6] == cbv_pkg::PAT_TAG) begin
                if (f == cbv_pkg::F_LEN) begin
                    n.len[p] = cfg_data_in[cbv_pkg::VPOS_W-1:0];
                end
                if (f == cbv_pkg::F_REP) begin
                    n.rep[p] = cfg_data_in[cbv_pkg::REP_W-1:0];
                end
                if (f == cbv_pkg::F_START) begin
                    n.start[p] = cfg_data_in[cbv_pkg::NV-1:0];
                end
                for (int v = 0; v < cbv_pkg::NV; v++) begin
                    if (f == 4'(cbv_pkg::F_TOG1 + v)) begin
                        n.tog1[p][v] = cfg_data_in[cbv_pkg::VPOS_W-1:0];
                    end
                    if (f == 4'(cbv_pkg::F_TOG2 + v)) begin
                        n.tog2[p][v] = cfg_data_in[cbv_pkg::VPOS_W-1:0];
                    end
                end
            end
        end

        // horizontal blanking sequence, stepped once per pixel
        n.sync_d = line_sync_in;
        case (q.hst)
            cbv_pkg::ST_ACTIVE: begin
                if (sync_fall) begin
                    n.ext_cnt = '0;
                    n.blk_cnt = '0;
                    if (q.ext_en && q.ext_len != '0) begin
                        n.hst = cbv_pkg::ST_EXTEND;
                    end else begin
                        n.hst = cbv_pkg::ST_BLANK;
                    end
                end
            end
            cbv_pkg::ST_EXTEND: begin
                // line counters outside stay frozen while this runs
                n.ext_cnt = cbv_pkg::cbv_ext_t'(q.ext_cnt + 1'b1);
                if (cbv_pkg::cbv_ext_t'(q.ext_cnt + 1'b1) == q.ext_len) begin
                    n.hst = cbv_pkg::ST_BLANK;
                end
            end
            cbv_pkg::ST_BLANK: begin
                // wraps only after 2048 blanked pixels, far beyond any line
                n.blk_cnt = cbv_blk_t'(q.blk_cnt + 1'b1);
                if (line_sync_in) begin
                    n.hst = cbv_pkg::ST_ACTIVE;
                end
            end
            default: begin
                n.hst = cbv_pkg::ST_ACTIVE;
            end
        endcase

        // line sub-counter holds during the extension
        if (q.hst != cbv_pkg::ST_EXTEND) begin
            n.hsub = sync_fall ? '0 : cbv_pkg::cbv_hpos_t'(q.hsub + 1'b1);
        end

        // retime stage: costs one pixel of blanking latency when selected
        n.blank_rt = blank_raw;
        n.hit_rt = hit;

        // phase a: level while blanked, optional pulses, free toggle otherwise
        if (blank_used) begin
            n.h1 = hit_used ? ~q.level : q.level;
        end else begin
            n.h1 = ~q.h1;
        end
        n.h2 = ~n.h1;

        // external gate latched on the line sync fall
        if (sync_fall) begin
            n.gate_lat = shared_sync_gate_pin_in;
        end

        // masking forces vertical clocks and clamp low
        n.vclk = mask ? '0 : vp.vout;
        n.clamp = mask ? 1'b0 : black_clamp_pulse_in;
        n.sync_o = line_sync_in;
    end

    // single state register
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= RST;
        end else begin
            q <= n;
        end
    end

    // outputs from flops or decoded flop state, output enable from slave_mode_in; pin is an input in slave mode
    assign shared_sync_gate_pin_out = q.sync_o;
    assign shared_sync_gate_pin_oe_out = ~slave_mode_in;
    assign horiz_clock_phase_a_out = q.h1;
    assign horiz_clock_phase_b_out = q.h2;
    assign vertical_clock_outputs_out = q.vclk;
    assign black_clamp_pulse_out = q.clamp;
    assign line_count_hold_out = (q.hst == cbv_pkg::ST_EXTEND);
    assign line_sub_counter_out = q.hsub;
    assign blank_active_out = blank_used;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_sync_fall;
        q.sync_d && !line_sync_in;
    endsequence

    sequence s_masked;
        slave_mode_in && q.gate_lat && (!q.shut_sel || mech_shutter_signal_in);
    endsequence

    sequence s_line_open;
        s_sync_fall ##0 q.hst == cbv_pkg::ST_ACTIVE;
    endsequence

    blank_level_a: assert property (blank_used && !q.pulse_en
            |=> horiz_clock_phase_a_out == $past(q.level))
        else $error("phase a not at blanking level");
    pulse_pos_a: assert property (blank_used && !q.retime && q.pulse_en
            && q.blk_cnt == cbv_blk_t'(q.hpos)
            |=> horiz_clock_phase_a_out != $past(q.level))
        else $error("no blanking pulse at programmed position");
    // both phases sit low in reset, so the check starts one edge after release
    phase_inv_a: assert property ($past(rstn_in)
            |-> horiz_clock_phase_b_out == !horiz_clock_phase_a_out)
        else $error("phase b not inverse of phase a");
    ext_hold_a: assert property (q.hst == cbv_pkg::ST_EXTEND
            |=> line_sub_counter_out == $past(line_sub_counter_out))
        else $error("line sub-counter moved during extension");
    ext_len_a: assert property (s_sync_fall ##0 q.hst == cbv_pkg::ST_ACTIVE
            ##0 q.ext_en && q.ext_len == 9'h003
            |=> line_count_hold_out [*3] ##1 !line_count_hold_out)
        else $error("extension length wrong");
    vstart_a: assert property (s_sync_fall |=> ##1 vertical_clock_outputs_out
            == ($past(mask) ? 4'h0 : $past(vp.start)))
        else $error("vertical start delayed");
    gate_latch_a: assert property (s_sync_fall
            |=> q.gate_lat == $past(shared_sync_gate_pin_in))
        else $error("gate not latched on line sync fall");
    mask_a: assert property (s_masked
            |=> vertical_clock_outputs_out == 4'h0 && !black_clamp_pulse_out)
        else $error("mask did not force outputs low");
    shut_block_a: assert property (q.shut_sel && !mech_shutter_signal_in
            |=> black_clamp_pulse_out == $past(black_clamp_pulse_in))
        else $error("gate masked while shutter low");
    retime_off_a: assert property (!q.retime && blank_raw && !q.pulse_en
            |=> horiz_clock_phase_a_out == $past(q.level))
        else $error("unretimed blanking late");
    retime_pulse_a: assert property (q.retime && blank_raw && q.pulse_en
            && q.blk_cnt == cbv_blk_t'(q.hpos)
            |=> ##1 horiz_clock_phase_a_out != $past(q.level))
        else $error("retimed blanking pulse not one pixel late");

    // master mode passes pattern and clamp straight through
    unmask_a: assert property (!slave_mode_in
            |=> vertical_clock_outputs_out == $past(vp.vout)
            && black_clamp_pulse_out == $past(black_clamp_pulse_in))
        else $error("outputs masked outside slave mode");

    // free toggle outside blanking; line opening: blanking starts, counters restart, extension engages
    free_toggle_a: assert property (!blank_used
            |=> horiz_clock_phase_a_out != $past(horiz_clock_phase_a_out))
        else $error("phase a did not toggle outside blanking");
    blank_enter_a: assert property (s_line_open |=> blank_raw)
        else $error("blanking did not start on line sync fall");
    sub_reset_a: assert property (s_sync_fall ##0 q.hst != cbv_pkg::ST_EXTEND
            |=> line_sub_counter_out == '0)
        else $error("line sub-counter not cleared on line sync fall");
    ext_entry_a: assert property (s_line_open ##0 q.ext_en && q.ext_len != '0
            |=> line_count_hold_out)
        else $error("extension did not hold the line counters");
endmodule // cbv_timing_top
`default_nettype wire

// [test/cbv_ccd_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cbv_ccd_model (
    input wire logic core_clk_in,
    input wire logic pin_out_in,
    input wire logic pin_oe_in,
    input wire logic gate_level_in,
    output logic line_sync_out,
    output logic pin_level_out
);
    // the shared pin shows the device's sync while it drives, else the gate from this side
    assign pin_level_out = pin_oe_in ? pin_out_in : gate_level_in;

    // line sync idles high so that the first low is seen as a fall
    initial begin
        line_sync_out = 1'b1;
    end

    // returns just after the edge that samples the fall
    task automatic start_line();
        @(negedge core_clk_in);
        line_sync_out = 1'b0;
        @(posedge core_clk_in);
    endtask

    // a few idle cycles keep the next fall clear of the last blanking
    task automatic end_line();
        @(negedge core_clk_in);
        line_sync_out = 1'b1;
        repeat (4) @(negedge core_clk_in);
    endtask
endmodule // cbv_ccd_model
`default_nettype wire

// [test/ccd_blanking_and_vertical_pattern_gen_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module ccd_blanking_and_vertical_pattern_gen_bench;
    logic clk, rstn, wr, slave, shut, clamp, gate, sync, pin, pin_o, pin_oe;
    logic ha, hb, clamp_o, hold, blk;
    logic [7:0] addr;
    logic [11:0] data;
    logic [2:0] region;
    logic [3:0] vclk, st;
    logic [9:0] cnt;
    int n_mismatch, num_checks;

    cbv_timing_top i_dut (
        .core_clk_in(clk), .rstn_in(rstn), .cfg_wr_in(wr), .cfg_addr_in(addr),
        .cfg_data_in(data), .slave_mode_in(slave), .line_sync_in(sync),
        .mech_shutter_signal_in(shut), .black_clamp_pulse_in(clamp), .region_in(region),
        .shared_sync_gate_pin_in(pin), .shared_sync_gate_pin_out(pin_o),
        .shared_sync_gate_pin_oe_out(pin_oe), .horiz_clock_phase_a_out(ha),
        .horiz_clock_phase_b_out(hb), .vertical_clock_outputs_out(vclk),
        .black_clamp_pulse_out(clamp_o), .line_count_hold_out(hold),
        .line_sub_counter_out(cnt), .blank_active_out(blk)
    );

    cbv_ccd_model i_ccd (
        .core_clk_in(clk), .pin_out_in(pin_o), .pin_oe_in(pin_oe),
        .gate_level_in(gate), .line_sync_out(sync), .pin_level_out(pin)
    );

    // free-running pixel clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe, driven off the sampling edge
    task automatic wr_reg(input logic [7:0] a, input logic [11:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        data = d;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic test_reset();
        repeat (8) @(negedge clk);
        chk({ha, hb, hold, blk, pin_o, clamp_o}, 12'h000);
        chk({vclk, cnt}, 12'h000);
        chk(pin_oe, !slave);
        rstn = 1'b1;
        @(negedge clk);
        chk({ha, hb}, 12'h002);
        $display("test reset done");
    endtask

    task automatic test_blank(input logic pe, lev, rt, ex, input logic [8:0] len,
                              input logic [9:0] pos);
        int lx, b;
        logic a0;
        logic [9:0] cprev;
        lx = ex ? int'(len) : 0;
        b = 2 + lx + int'(rt);
        st = st ^ 4'hF;
        wr_reg(8'h01, {11'h000, lev});
        wr_reg(8'h03, {11'h000, rt});
        wr_reg(8'h0A, {10'h000, ex, pe});
        wr_reg(8'h10, {2'h0, pos});
        wr_reg(8'h11, {3'h0, len});
        wr_reg(8'h0F, 12'hFFF); // unmapped, must leave everything alone
        wr_reg(8'h42, {8'h00, st});
        a0 = ha;
        @(negedge clk);
        chk(ha, !a0);
        i_ccd.start_line();
        for (int k = 1; k <= b + int'(pos) + 6; k++) begin
            @(negedge clk);
            if (k == 1) chk(pin_o, 1'b0);
            chk(hold, k <= lx);
            if (k > 1 && k <= lx) chk(cnt, cprev);
            cprev = cnt;
            if (k >= 2) chk(vclk, st);
            chk(hb, !ha);
            if (k >= b) chk(blk, 1'b1);
            if (k >= b) chk(ha, lev ^ (pe && (k == b + pos || k == b + pos + 2)));
        end
        i_ccd.end_line();
        $display("test blank pe=%0d lev=%0d rt=%0d ext=%0d done", pe, lev, rt, ex);
    endtask

    // every shutter-select, shutter and gate combination, then master mode
    task automatic test_gate();
        logic m;
        wr_reg(8'h42, 12'h00F);
        clamp = 1'b1;
        for (int i = 0; i < 9; i++) begin
            wr_reg(8'h01, {10'h000, i[2] && i < 8, 1'b0});
            slave = (i != 8);
            shut = i[1];
            gate = i[0] || i == 8;
            m = slave && gate && (!i[2] || shut);
            i_ccd.start_line();
            chk(pin_oe, !slave);
            for (int k = 1; k <= 6; k++) begin
                @(negedge clk);
                if (k == 1) gate = ~gate;
                if (k >= 2) chk({clamp_o, vclk}, m ? 12'h000 : 12'h01F);
            end
            i_ccd.end_line();
        end
        $display("test gate done");
    endtask

    task automatic test_seq();
        int t1[4] = '{2, 3, 4, 1};
        int t2[4] = '{5, 6, 6, 1};
        logic [3:0] e;
        int p;
        wr_reg(8'h40, 12'h008);
        wr_reg(8'h41, 12'h002);
        wr_reg(8'h42, 12'h006);
        for (int v = 0; v < 4; v++) begin
            wr_reg(8'h44 + 8'(v), 12'(t1[v]));
            wr_reg(8'h48 + 8'(v), 12'(t2[v]));
        end
        i_ccd.start_line();
        @(negedge clk);
        for (int k = 0; k < 16; k++) begin
            @(negedge clk);
            p = k % 8;
            for (int v = 0; v < 4; v++) begin
                e[v] = (v == 1 || v == 2) ^ (t1[v] < p) ^ (t2[v] < p && t2[v] != t1[v]);
            end
            chk(vclk, e);
        end
        i_ccd.end_line();
        $display("test sequence done");
    endtask

    // each region points at its own entry, each entry at a pattern
    task automatic test_region();
        logic [3:0] sv[4] = '{4'h9, 4'h6, 4'hC, 4'h3};
        wr_reg(8'h41, 12'h000);
        for (int q = 0; q < 4; q++) wr_reg(8'h42 + 8'(q * 16), {8'h00, sv[q]});
        for (int r = 0; r < 5; r++) begin
            wr_reg(8'h18 + 8'(r), 12'(4 - r));
            wr_reg(8'h20 + 8'(4 - r), 12'((r + 1) % 4));
            region = 3'(r);
            i_ccd.start_line();
            repeat (2) @(negedge clk);
            for (int k = 2; k <= 9; k++) begin
                chk(vclk, sv[(r + 1) % 4]);
                @(negedge clk);
            end
            i_ccd.end_line();
        end
        $display("test region done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // cuts a hang short well above the longest expected run
    initial begin
        repeat (20000) @(posedge clk);
        $display("watchdog expired");
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        rstn = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        data = 12'h000;
        slave = 1'b0;
        shut = 1'b0;
        clamp = 1'b0;
        gate = 1'b0;
        region = 3'h0;
        st = 4'h5;
        test_reset();
        test_blank(1'b0, 1'b0, 1'b0, 1'b0, 9'h000, 10'h005);
        test_blank(1'b1, 1'b0, 1'b0, 1'b0, 9'h000, 10'h003);
        test_blank(1'b1, 1'b1, 1'b1, 1'b0, 9'h000, 10'h000);
        test_blank(1'b0, 1'b1, 1'b0, 1'b1, 9'h003, 10'h002);
        test_blank(1'b1, 1'b0, 1'b1, 1'b1, 9'h005, 10'h007);
        test_blank(1'b1, 1'b1, 1'b0, 1'b0, 9'h000, 10'h3FF);
        test_blank(1'b1, 1'b0, 1'b0, 1'b1, 9'h1FF, 10'h001);
        test_gate();
        test_seq();
        test_region();
        report_and_stop();
    end
endmodule // ccd_blanking_and_vertical_pattern_gen_bench
`default_nettype wire
